// file: inc/tti_defines.vh
// Constants for the transport trigger block
`ifndef TTI_DEFINES_VH
`define TTI_DEFINES_VH
`define TTI_ADDR_W        4
`define TTI_REG_CTRL      4'h0
`define TTI_REG_HOLD      4'h1
`define TTI_REG_STAT      4'h2
`define TTI_REG_CMD       4'h3
`define TTI_REG_TC        4'h4
`define TTI_CTRL_IN_POL   0
`define TTI_CTRL_OUT_POL  1
`define TTI_CTRL_TC_SRC   2
`define TTI_CTRL_ABS_STOP 3
`define TTI_CTRL_TC_MODE  4
`define TTI_CTRL_RESET    32'h00000000
`define TTI_HOLD_RESET    32'h00000000
`define TTI_MODE_FREE     2'h0
`define TTI_MODE_FREE_MUTE 2'h1
`define TTI_MODE_DAY_MUTE 2'h2
`define TTI_MODE_EXT      2'h3
`define TTI_DEB_US        1
`define TTI_DEB_CYC       ((`TTI_DEB_US * 250))
`define TTI_LOSS_MS       100
`define TTI_LOSS_CYC      ((`TTI_LOSS_MS * 250000))
`define TTI_ST_STOP       2'h0
`define TTI_ST_PLAY       2'h1
`define TTI_ST_ARM        2'h2
`define TTI_ST_REC        2'h3
`endif

// file: design/tti_debounce.v
// Synchroniser, debouncer and edge pulse for one trigger line
`timescale 1ns/1ns
`default_nettype none
module tti_debounce #(
  parameter CNT_W = 16,
  parameter DEB   = 250
) (
  input  wire mclk,
  input  wire sys_rst,
  input  wire pin,
  input  wire active_high,
  output reg  pulse
);
  reg             sync_a;
  reg             sync_b;
  reg             stable;
  reg [CNT_W-1:0] cnt;
  localparam integer DEB_LAST = DEB - 1;
  wire            act = active_high ? sync_b : ~sync_b;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      stable <= 1'b0;
      cnt    <= {CNT_W{1'b0}};
      pulse  <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      pulse  <= 1'b0;
      if (act == stable) begin
        cnt <= {CNT_W{1'b0}};
      end else if (cnt == DEB_LAST[CNT_W-1:0]) begin
        cnt    <= {CNT_W{1'b0}};
        stable <= act;
        pulse  <= act;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/tti_top.v
// Transport trigger inputs, status outputs and timecode record run
//Contract
//- Three trigger inputs request record, play and stop.
//- Three status outputs show recording, playing and stopped.
//- Input group and output group each have one polarity setting.
//- Active-high inputs trigger at supply level, active-low at ground.
//- Active-high outputs drive supply when active, active-low pull to ground.
//- Timecode source starts record when timecode advances, stops when it halts.
//- Absent-timecode mode also stops recording when timecode signal disappears.
//- Hold-off: capture at once, record only if timecode still valid afterwards.
//- Muted run modes silence timecode output while stopped, count keeps going.
//- Record triggering never changes which timecode gets stamped.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "tti_defines.vh"
module tti_top #(
  parameter LOSS_CYC = `TTI_LOSS_CYC,
  parameter HOLD_W   = 32
) (
  input  wire                   mclk,
  input  wire                   sys_rst,
  input  wire [2:0]             trig_in,
  output reg  [2:0]             stat_out,
  output reg  [2:0]             stat_oe,
  input  wire                   tc_valid,
  input  wire [31:0]            tc_value,
  input  wire                   ltc_present,
  output reg                    tc_out_mute,
  output reg                    capture,
  output reg  [31:0]            stamp_tc,
  input  wire [`TTI_ADDR_W-1:0] reg_addr,
  input  wire [31:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [31:0]            reg_rdata
);
  reg  [31:0]       ctrl;
  reg  [HOLD_W-1:0] hold;
  reg  [1:0]        state;
  reg  [1:0]        next_state;
  reg  [HOLD_W-1:0] hold_cnt;
  reg  [31:0]       loss_cnt;
  reg  [31:0]       int_tc;
  reg               tv_a;
  reg               tv_b;
  reg               lp_a;
  reg               lp_b;
  reg  [31:0]       tcv_a;
  reg  [31:0]       tcv_b;
  reg  [31:0]       tc_last;
  reg               tc_run;
  reg  [2:0]        sw_cmd;
  wire [2:0]        req;
  wire              in_pol   = ctrl[`TTI_CTRL_IN_POL];
  wire              out_pol  = ctrl[`TTI_CTRL_OUT_POL];
  wire              tc_src   = ctrl[`TTI_CTRL_TC_SRC];
  wire              abs_stop = ctrl[`TTI_CTRL_ABS_STOP];
  wire [1:0]        tc_mode  = ctrl[`TTI_CTRL_TC_MODE+1:`TTI_CTRL_TC_MODE];
  wire              tc_move  = tv_b && (tcv_b != tc_last);
  wire              ltc_lost = (loss_cnt >= LOSS_CYC);
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : trig
      tti_debounce #(
        .CNT_W (16),
        .DEB   (`TTI_DEB_CYC)
      ) u_deb (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .pin         (trig_in[g]),
        .active_high (in_pol),
        .pulse       (req[g])
      );
    end
  endgenerate

  function [2:0] stat_of;
    input [1:0] st;
    begin
      case (st)
        `TTI_ST_REC:  stat_of = 3'h1;
        `TTI_ST_PLAY: stat_of = 3'h2;
        `TTI_ST_ARM:  stat_of = 3'h4;
        default:      stat_of = 3'h4;
      endcase
    end
  endfunction

  // Transport state
  always @* begin
    next_state = state;
    case (state)
      `TTI_ST_STOP: begin
        if (req[0] || sw_cmd[0]) begin
          next_state = `TTI_ST_REC;
        end else if (req[1] || sw_cmd[1]) begin
          next_state = `TTI_ST_PLAY;
        end else if (tc_src && tc_run && !(abs_stop && ltc_lost)) begin
          next_state = (hold == {HOLD_W{1'b0}}) ? `TTI_ST_REC : `TTI_ST_ARM;
        end
      end
      `TTI_ST_PLAY: begin
        if (req[2] || sw_cmd[2]) begin
          next_state = `TTI_ST_STOP;
        end else if (req[0] || sw_cmd[0]) begin
          next_state = `TTI_ST_REC;
        end
      end
      `TTI_ST_ARM: begin
        if (req[2] || sw_cmd[2]) begin
          next_state = `TTI_ST_STOP;
        end else if (hold_cnt >= hold) begin
          next_state = (tv_b && tc_run) ? `TTI_ST_REC : `TTI_ST_STOP;
        end
      end
      `TTI_ST_REC: begin
        if (req[2] || sw_cmd[2]) begin
          next_state = `TTI_ST_STOP;
        end else if (tc_src && !tc_run) begin
          next_state = `TTI_ST_STOP;
        end else if (tc_src && abs_stop && ltc_lost) begin
          next_state = `TTI_ST_STOP;
        end
      end
      default: next_state = `TTI_ST_STOP;
    endcase
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= `TTI_ST_STOP;
      hold_cnt    <= {HOLD_W{1'b0}};
      loss_cnt    <= 32'h00000000;
      int_tc      <= 32'h00000000;
      tv_a        <= 1'b0;
      tv_b        <= 1'b0;
      lp_a        <= 1'b0;
      lp_b        <= 1'b0;
      tcv_a       <= 32'h00000000;
      tcv_b       <= 32'h00000000;
      tc_last     <= 32'h00000000;
      tc_run      <= 1'b0;
      stat_out    <= 3'h0;
      stat_oe     <= 3'h0;
      tc_out_mute <= 1'b0;
      capture     <= 1'b0;
      stamp_tc    <= 32'h00000000;
    end else begin
      tv_a    <= tc_valid;
      tv_b    <= tv_a;
      lp_a    <= ltc_present;
      lp_b    <= lp_a;
      tcv_a   <= tc_value;
      tcv_b   <= tcv_a;
      tc_last <= tcv_b;
      if (tv_b) begin
        tc_run <= tc_move;
      end else begin
        tc_run <= 1'b0;
      end
      loss_cnt <= lp_b ? 32'h00000000 : (ltc_lost ? loss_cnt : loss_cnt + 32'h00000001);
      state    <= next_state;
      hold_cnt <= (state == `TTI_ST_ARM) ? hold_cnt + 1'b1 : {HOLD_W{1'b0}};
      int_tc   <= int_tc + 32'h00000001;
      stat_out <= out_pol ? stat_of(next_state) : ~stat_of(next_state);
      stat_oe  <= 3'h7;
      tc_out_mute <= ((tc_mode == `TTI_MODE_FREE_MUTE) ||
                      (tc_mode == `TTI_MODE_DAY_MUTE)) &&
                     (next_state == `TTI_ST_STOP);
      capture  <= (next_state == `TTI_ST_ARM) || (next_state == `TTI_ST_REC);
      stamp_tc <= (tc_mode == `TTI_MODE_EXT) ? tcv_b : int_tc;
    end
  end

  // Register port
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl      <= `TTI_CTRL_RESET;
      hold      <= `TTI_HOLD_RESET;
      sw_cmd    <= 3'h0;
      reg_rdata <= 32'h00000000;
    end else begin
      sw_cmd    <= 3'h0;
      reg_rdata <= 32'h00000000;
      if (reg_wr) begin
        case (reg_addr)
          `TTI_REG_CTRL: ctrl   <= {26'h0, reg_wdata[5:0]};
          `TTI_REG_HOLD: hold   <= reg_wdata[HOLD_W-1:0];
          `TTI_REG_CMD:  sw_cmd <= reg_wdata[2:0];
          default:       ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `TTI_REG_CTRL: reg_rdata <= ctrl;
          `TTI_REG_HOLD: reg_rdata <= hold;
          `TTI_REG_STAT: reg_rdata <= {24'h0, lp_b, tc_run, tc_out_mute, capture, 2'h0, state};
          `TTI_REG_TC:   reg_rdata <= int_tc;
          default:       reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tti_far_side.sv
// Switch contacts and timecode source facing the trigger block
`timescale 1ns/1ns
`default_nettype none
module tti_far_side (
  input  wire logic        mclk,
  input  wire logic        in_high,
  input  wire logic [2:0]  press,
  input  wire logic        roll,
  input  wire logic        tc_on,
  input  wire logic        ltc_on,
  output logic      [2:0]  trig_in,
  output logic             tc_valid,
  output var logic  [31:0] tc_value,
  output logic             ltc_present
);
  assign trig_in = in_high ? press : ~press;
  assign tc_valid = tc_on;
  assign ltc_present = ltc_on;
  initial tc_value = 32'h0;
  always @(posedge mclk) begin
    if (!tc_on) begin
      tc_value <= ~tc_value;
    end else if (roll) begin
      tc_value <= tc_value + 32'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb/tti_top_chk.sv
// Port assertions for the trigger block
`timescale 1ns/1ns
`default_nettype none
module tti_chk (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [2:0]  stat_out,
  input wire logic [2:0]  stat_oe,
  input wire logic        capture,
  input wire logic        tc_out_mute,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic rec = stat_out == 3'h1 || stat_out == 3'h6;
  chk_oe_on: assert property (!$past(sys_rst) |-> stat_oe == 3'h7)
    else $error("oe low");
  chk_one_hot: assert property (!$past(sys_rst) |-> $onehot(stat_out) || $onehot(~stat_out))
    else $error("bad status");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("rdata");
  chk_ctrl_back: assert property (reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0
    |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 2)) else $error("ctrl readback");
  chk_hold_back: assert property (reg_wr && reg_addr == 4'h1 ##1 reg_rd && reg_addr == 4'h1
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("hold readback");
  chk_stop_cmd: assert property (reg_wr && reg_addr == 4'h3 && reg_wdata == 32'h4
    |-> ##[1:4] (stat_out == 3'h4 || stat_out == 3'h3)) else $error("no stop");
  chk_rec_capt: assert property (rec && $past(rec) |-> capture) else $error("capture");
  chk_mute_stop: assert property (tc_out_mute && $past(tc_out_mute)
    |-> !rec && stat_out != 3'h2 && stat_out != 3'h5) else $error("mute");
endmodule
bind tti_top tti_chk i_chk (.mclk(mclk), .sys_rst(sys_rst), .stat_out(stat_out),
  .stat_oe(stat_oe), .capture(capture), .tc_out_mute(tc_out_mute), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// file: tb/tti_top_bench.sv
// Self-checking bench for the trigger block
`timescale 1ns/1ns
`default_nettype none
`include "tti_defines.vh"
module tti_top_bench;
  logic        mclk, sys_rst, roll, tc_on, ltc_on, reg_wr, reg_rd, tc_valid;
  logic        ltc_present, tc_out_mute, capture;
  logic [2:0]  press, trig_in, stat_out, stat_oe;
  logic [3:0]  reg_addr;
  logic [31:0] tc_value, stamp_tc, reg_wdata, reg_rdata, ctrl, v;
  integer      n_mismatch = 0, cmp_count = 0, seed = 12, i;
  tti_far_side i_far (.mclk, .in_high(ctrl[0]), .press, .roll, .tc_on, .ltc_on, .trig_in,
    .tc_valid, .tc_value, .ltc_present);
  tti_top #(.LOSS_CYC(20)) i_dut (.mclk, .sys_rst, .trig_in, .stat_out, .stat_oe, .tc_valid,
    .tc_value, .ltc_present, .tc_out_mute, .capture, .stamp_tc, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a == 4'h0) ctrl = d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic wr_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    if (a == 4'h0) ctrl = d;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic see(input logic [2:0] st, input integer n);
    logic [2:0] e;
    e = ctrl[1] ? st : ~st;
    for (int k = 0; k < n && stat_out !== e; k++) @(posedge mclk) #1;
    chk({29'h0, stat_out}, {29'h0, e});
  endtask
  task automatic hit(input integer b);
    press[b] <= 1'b1;
    repeat (300) @(posedge mclk);
    press[b] <= 1'b0;
    repeat (300) @(posedge mclk);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000 n_mismatch++;
    test_done;
  end
  initial begin
    {press, roll, tc_on, reg_wr, reg_rd, reg_addr, reg_wdata, ctrl} = 0;
    sys_rst = 1;
    ltc_on = 1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(4'h0, `TTI_CTRL_RESET);
    rd(4'h1, `TTI_HOLD_RESET);
    rd(4'h9, 32'h0);
    rd(4'h2, 32'h00000080);
    see(3'h4, 4);
    hit(0); see(3'h1, 4);
    hit(2); see(3'h4, 4);
    hit(1); see(3'h2, 4);
    $display("pins active low done");
    wr(4'h0, 32'h3);
    hit(2); see(3'h4, 4);
    hit(0); see(3'h1, 4);
    press[0] <= 1'b1;
    repeat (300) @(posedge mclk);
    wr(4'h3, 32'h4);
    repeat (400) @(posedge mclk);
    see(3'h4, 1);
    press[0] <= 1'b0;
    wr(4'h3, 32'h2); see(3'h2, 4);
    wr(4'h3, 32'h1); see(3'h1, 4);
    wr(4'h3, 32'h4); see(3'h4, 4);
    $display("pins active high done");
    wr(4'h0, 32'h7); tc_on <= 1'b1; roll <= 1'b1; see(3'h1, 20);
    roll <= 1'b0; see(3'h4, 20);
    wr(4'h0, 32'hF); roll <= 1'b1; see(3'h1, 20);
    ltc_on <= 1'b0; repeat (10) @(posedge mclk); see(3'h1, 1);
    see(3'h4, 40);
    repeat (40) @(posedge mclk);
    #1 see(3'h4, 1);
    roll <= 1'b0; ltc_on <= 1'b1; repeat (8) @(posedge mclk);
    wr(4'h0, 32'h7); see(3'h4, 20);
    wr(4'h1, 32'd50); roll <= 1'b1; repeat (10) @(posedge mclk);
    #1 chk(capture, 1); see(3'h4, 1); see(3'h1, 80);
    roll <= 1'b0; see(3'h4, 20);
    roll <= 1'b1; repeat (10) @(posedge mclk);
    tc_on <= 1'b0; repeat (80) @(posedge mclk);
    #1 see(3'h4, 1); chk(capture, 0);
    $display("timecode run done");
    roll <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(4'h0, {26'h0, i[1:0], 4'h3}); tc_on <= 1'b1; repeat (4) @(posedge mclk);
      #1 chk(tc_out_mute, i == 1 || i == 2);
      if (i == 3) chk(stamp_tc, tc_value);
      v = stamp_tc;
      @(posedge mclk) #1;
      if (i != 3) chk(stamp_tc, v + 32'h1);
    end
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      wr_rd(4'h1, v, v);
      wr_rd(4'h0, v, {26'h0, v[5:0]});
    end
    $display("mute and hold done");
    test_done;
  end
endmodule
`default_nettype wire
